// [hdl/arc_pkg.sv]
// constants, register map and carrier types for the converter control block
// assumes a single system clock and a plain strobe register port
`default_nettype none
package arc_pkg;
	localparam int NCONV = 2;
	localparam int NRES = 8;
	localparam int NCH = 16;
	localparam int QDEPTH = 4;
	localparam int SAR_W = 10;
	localparam int RES_W = 12;
	// register addresses
	localparam logic [4:0] A_CTRL = 5'h00;
	localparam logic [4:0] A_TIME = 5'h01;
	localparam logic [4:0] A_PARA = 5'h02;
	localparam logic [4:0] A_PARB = 5'h03;
	localparam logic [4:0] A_TRIG = 5'h04;
	localparam logic [4:0] A_START = 5'h05;
	localparam logic [4:0] A_QUEUE = 5'h06;
	localparam logic [4:0] A_INSERT = 5'h07;
	localparam logic [4:0] A_LIMLO = 5'h08;
	localparam logic [4:0] A_LIMHI = 5'h09;
	localparam logic [4:0] A_WFR = 5'h0A;
	localparam logic [4:0] A_DIGDIS = 5'h0B;
	localparam logic [4:0] A_STAT = 5'h0C;
	localparam logic [4:0] A_PINS = 5'h0D;
	localparam logic [4:0] A_FIFOA = 5'h0E;
	localparam logic [4:0] A_FIFOB = 5'h0F;
	localparam int A_RES_BIT = 4;
	// control register fields
	localparam int C_EN = 0;
	localparam int C_RES8 = 2;
	localparam int C_SYNC = 3;
	localparam int C_FIFO = 4;
	localparam int C_LIM = 5;
	localparam int C_ACC = 6;
	localparam int C_BWD = 8;
	localparam int C_MTEST = 9;
	localparam int C_PARHI = 10;
	localparam int C_EMUX = 11;
	localparam int F_CONV = 4;
	localparam int F_VALID = 15;
	// reset values and bit positions
	localparam logic [15:0] CTRL_RST = 16'h0000;
	localparam logic [15:0] TIME_RST = 16'h0104;
	localparam logic [3:0] BIT_TOP = 4'h9;
	localparam logic [3:0] BIT_STOP8 = 4'h2;
	localparam logic [SAR_W-1:0] SAR_ONE = 10'h001;
	localparam logic [1:0] SRC_INS = 2'h0;
	localparam logic [1:0] SRC_PAR = 2'h1;
	localparam logic [1:0] SRC_Q = 2'h2;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [4:0] addr;
		logic [15:0] wdata;
	} arc_bus_t;

	typedef struct packed {
		logic pwr;
		logic samp;
		logic bwd_pre;
		logic [3:0] sel;
		logic [2:0] emux;
		logic [SAR_W-1:0] dac;
	} arc_ana_t;

	typedef struct packed {
		logic v;
		logic [1:0] src;
		logic [3:0] ch;
	} arc_gnt_t;

	typedef enum logic [1:0] {ST_IDLE, ST_SAMP, ST_CONV, ST_STORE} arc_st_t;
endpackage
`default_nettype wire

// [hdl/arc_top.sv]
// request, arbitration, sequencing and result logic for two SAR converters
// assumes synchronous inputs, comparator high when input >= dac trial value
//
// Overview of operation
// R1 - two independent converters, each giving 10-bit results
// R2 - software selects an 8-bit mode that needs fewer bit steps
// R3 - sixteen selectable channels per converter, four inputs shared by both
// R4 - each conversion is a successive-approximation bit sequence
// R5 - sample and per-bit conversion durations are programmable
// R6 - sync mode starts sampling on both converters together
// R7 - external multiplexer select steps automatically after each conversion
// R8 - pin levels stay readable as digital inputs
// R9 - parallel requests start on triggers, transfer-controller starts or software
// R10 - parallel source converts its selected channels lowest number first
// R11 - queue converts channels in the order software pushed them
// R12 - an inserted single channel runs next, sequence then resumes unchanged
// R13 - arbiter grants the highest-priority pending source
// R14 - results may be accumulated or discarded when inside limits
// R15 - eight result registers per converter, optionally chained as a FIFO
// R16 - each result register has its own wait-for-read enable
// R17 - a done pulse per conversion serves the event transfer controller
// R18 - digital input of each pin can be disabled by software
// R19 - analog section powered only while converting
// R20 - broken-wire precharge and flag per conversion, multiplexer test output
// R21 - conversion into a protected unread register is held back
// R22 - FIFO reads return oldest first and free that stage
`default_nettype none
module arc_top
	import arc_pkg::*;
(
	// clock and reset
	input wire logic i_clk_sys,
	input wire logic i_resetn,
	// register port
	input wire arc_bus_t i_bus,
	output logic [15:0] o_rdata,
	// triggers
	input wire logic [3:0] i_trig,
	input wire logic [NCONV-1:0] i_etc_start,
	// analog side
	input wire logic [NCONV-1:0] i_cmp,
	input wire logic [NCH-1:0] i_pin,
	output arc_ana_t [NCONV-1:0] o_ana,
	output logic o_mtest,
	// events
	output logic [NCONV-1:0] o_done
);
	logic [15:0] ctrl_r, time_r, lim_lo_r, lim_hi_r, digdis_r;
	logic [NCH-1:0] par_mask_r [NCONV];
	logic [NCH-1:0] pend_r [NCONV];
	logic [3:0] trig_en_r [NCONV];
	logic [NRES-1:0] wfr_r [NCONV];
	logic [3:0] trig_q_r;
	logic [3:0] q_r [NCONV][QDEPTH];
	logic [2:0] q_cnt_r [NCONV];
	logic ins_v_r [NCONV];
	logic [3:0] ins_ch_r [NCONV];
	arc_st_t st_r [NCONV];
	logic [7:0] cnt_r [NCONV];
	logic [3:0] bit_r [NCONV];
	logic [SAR_W-1:0] sar_r [NCONV];
	logic [2:0] tgt_r [NCONV];
	logic [RES_W-1:0] acc_r [NCONV];
	logic [1:0] acc_n_r [NCONV];
	logic [RES_W-1:0] res_r [NCONV][NRES];
	logic [NRES-1:0] val_r [NCONV];
	logic [2:0] wp_r [NCONV];
	logic [2:0] rp_r [NCONV];
	logic [NCONV-1:0] limf_r, bwf_r;
	arc_gnt_t gnt [NCONV];
	logic [2:0] tgt [NCONV];
	logic [RES_W-1:0] sum [NCONV];
	logic [NCONV-1:0] blk, req, idle, go, inlim, load, pop_q, push_q;
	logic [15:0] rdata_nxt;
	logic [3:0] rise;

	// picks the next channel: insert, then parallel or queue by priority
	function automatic arc_gnt_t arb(input logic iv, input logic [3:0] ich,
			input logic [NCH-1:0] pm, input logic qv, input logic [3:0] qch,
			input logic parhi);
		arc_gnt_t g;
		logic pv;
		logic [3:0] pch;
		g = '0;
		pv = 1'b0;
		pch = 4'h0;
		for (int i = NCH - 1; i >= 0; i--) begin
			if (pm[i]) begin
				pv = 1'b1;
				pch = 4'(i); // R10
			end
		end
		if (iv) begin
			g = '{1'b1, SRC_INS, ich}; // R12
		end else if (pv && (parhi || !qv)) begin
			g = '{1'b1, SRC_PAR, pch}; // R13
		end else if (qv) begin
			g = '{1'b1, SRC_Q, qch}; // R11
		end
		return g;
	endfunction

	assign rise = i_trig & ~trig_q_r;

	always_comb begin
		for (int c = 0; c < NCONV; c++) begin
			gnt[c] = arb(ins_v_r[c], ins_ch_r[c], pend_r[c], q_cnt_r[c] != 3'h0,
				q_r[c][0], ctrl_r[C_PARHI]);
			tgt[c] = ctrl_r[C_FIFO] ? wp_r[c] : gnt[c].ch[2:0];
			blk[c] = wfr_r[c][tgt[c]] & val_r[c][tgt[c]]; // R21
			req[c] = ctrl_r[C_EN + c] & gnt[c].v & ~blk[c];
			idle[c] = st_r[c] == ST_IDLE;
			sum[c] = acc_r[c] + (ctrl_r[C_RES8] ? RES_W'(sar_r[c] >> BIT_STOP8)
				: RES_W'(sar_r[c])); // R14
			inlim[c] = ctrl_r[C_LIM] && sum[c] >= lim_lo_r[RES_W-1:0]
				&& sum[c] <= lim_hi_r[RES_W-1:0];
			load[c] = (|(rise & trig_en_r[c])) | i_etc_start[c]
				| (i_bus.wr && i_bus.addr == A_START && i_bus.wdata[c]); // R9
			push_q[c] = i_bus.wr && i_bus.addr == A_QUEUE
				&& i_bus.wdata[F_CONV] == c[0] && q_cnt_r[c] != 3'(QDEPTH);
		end
		for (int c = 0; c < NCONV; c++) begin
			go[c] = idle[c] & req[c] & (~ctrl_r[C_SYNC] | (&req & &idle)); // R6
			pop_q[c] = go[c] && gnt[c].src == SRC_Q;
		end
	end

	// configuration registers
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			ctrl_r <= CTRL_RST;
			time_r <= TIME_RST;
			lim_lo_r <= 16'h0000;
			lim_hi_r <= 16'h0000;
			digdis_r <= 16'h0000;
			par_mask_r <= '{default: '0};
			trig_en_r <= '{default: '0};
			wfr_r <= '{default: '0};
		end else if (i_bus.wr) begin
			unique case (i_bus.addr)
				A_CTRL: ctrl_r <= i_bus.wdata;
				A_TIME: time_r <= i_bus.wdata; // R5
				A_PARA: par_mask_r[0] <= i_bus.wdata;
				A_PARB: par_mask_r[1] <= i_bus.wdata;
				A_TRIG: trig_en_r <= '{i_bus.wdata[3:0], i_bus.wdata[7:4]};
				A_LIMLO: lim_lo_r <= i_bus.wdata;
				A_LIMHI: lim_hi_r <= i_bus.wdata;
				A_WFR: wfr_r <= '{i_bus.wdata[7:0], i_bus.wdata[15:8]}; // R16
				A_DIGDIS: digdis_r <= i_bus.wdata; // R18
				default: ;
			endcase
		end
	end

	// request sources: parallel pending, queue, insert
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			trig_q_r <= 4'h0;
			pend_r <= '{default: '0};
			q_r <= '{default: '{default: '0}};
			q_cnt_r <= '{default: '0};
			ins_v_r <= '{default: 1'b0};
			ins_ch_r <= '{default: '0};
		end else begin
			trig_q_r <= i_trig;
			for (int c = 0; c < NCONV; c++) begin
				pend_r[c] <= (pend_r[c] & ~((go[c] && gnt[c].src == SRC_PAR)
					? (NCH'(1) << gnt[c].ch) : '0)) | (load[c] ? par_mask_r[c] : '0);
				if (pop_q[c]) begin
					for (int i = 0; i < QDEPTH - 1; i++) begin
						q_r[c][i] <= q_r[c][i+1]; // R11
					end
				end
				if (push_q[c]) begin
					q_r[c][2'(q_cnt_r[c] - 3'(pop_q[c]))] <= i_bus.wdata[3:0];
				end
				q_cnt_r[c] <= q_cnt_r[c] + 3'(push_q[c]) - 3'(pop_q[c]);
				if (go[c] && gnt[c].src == SRC_INS) begin
					ins_v_r[c] <= 1'b0;
				end
				if (i_bus.wr && i_bus.addr == A_INSERT && i_bus.wdata[F_CONV] == c[0]) begin
					ins_v_r[c] <= 1'b1; // R12
					ins_ch_r[c] <= i_bus.wdata[3:0];
				end
			end
		end
	end

	// conversion sequencer and result store
	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			st_r <= '{default: ST_IDLE};
			cnt_r <= '{default: '0};
			bit_r <= '{default: '0};
			sar_r <= '{default: '0};
			tgt_r <= '{default: '0};
			acc_r <= '{default: '0};
			acc_n_r <= '{default: '0};
			res_r <= '{default: '{default: '0}};
			val_r <= '{default: '0};
			wp_r <= '{default: '0};
			rp_r <= '{default: '0};
			limf_r <= '0;
			bwf_r <= '0;
			o_ana <= '0;
			o_done <= '0;
		end else begin
			if (i_bus.rd && i_bus.addr == A_STAT) begin
				limf_r <= '0;
				bwf_r <= '0;
			end
			for (int c = 0; c < NCONV; c++) begin
				o_done[c] <= 1'b0;
				if (i_bus.rd && i_bus.addr[A_RES_BIT] && i_bus.addr[3] == c[0]) begin
					val_r[c][i_bus.addr[2:0]] <= 1'b0;
				end
				if (i_bus.rd && i_bus.addr == (c == 0 ? A_FIFOA : A_FIFOB)
						&& val_r[c][rp_r[c]]) begin
					val_r[c][rp_r[c]] <= 1'b0; // R22
					rp_r[c] <= rp_r[c] + 3'h1;
				end
				unique case (st_r[c])
					ST_IDLE: begin
						o_ana[c].pwr <= go[c]; // R19
						if (go[c]) begin
							st_r[c] <= ST_SAMP;
							cnt_r[c] <= time_r[7:0];
							o_ana[c].samp <= 1'b1;
							o_ana[c].bwd_pre <= ctrl_r[C_BWD]; // R20
							o_ana[c].sel <= gnt[c].ch; // R3
							tgt_r[c] <= tgt[c];
						end
					end
					ST_SAMP: begin
						o_ana[c].bwd_pre <= 1'b0;
						cnt_r[c] <= cnt_r[c] - 8'h01;
						if (cnt_r[c] == 8'h00) begin
							o_ana[c].samp <= 1'b0;
							st_r[c] <= ST_CONV;
							bit_r[c] <= BIT_TOP;
							o_ana[c].dac <= SAR_ONE << BIT_TOP;
							cnt_r[c] <= {4'h0, time_r[11:8]};
						end
					end
					ST_CONV: begin
						cnt_r[c] <= cnt_r[c] - 8'h01;
						if (cnt_r[c] == 8'h00) begin
							cnt_r[c] <= {4'h0, time_r[11:8]};
							bit_r[c] <= bit_r[c] - 4'h1;
							if (!i_cmp[c]) begin
								o_ana[c].dac[bit_r[c]] <= 1'b0; // R4
							end
							if (bit_r[c] > 4'h0 && !(ctrl_r[C_RES8] && bit_r[c] == BIT_STOP8)) begin
								o_ana[c].dac[bit_r[c] - 4'h1] <= 1'b1;
							end else begin
								st_r[c] <= ST_STORE; // R2
								sar_r[c] <= i_cmp[c] ? o_ana[c].dac
									: o_ana[c].dac & ~(SAR_ONE << bit_r[c]); // R1
							end
						end
					end
					ST_STORE: begin
						st_r[c] <= ST_IDLE;
						o_ana[c].pwr <= 1'b0;
						o_ana[c].dac <= '0;
						o_done[c] <= 1'b1; // R17
						if (ctrl_r[C_EMUX]) begin
							o_ana[c].emux <= o_ana[c].emux + 3'h1; // R7
						end
						if (ctrl_r[C_BWD] && sar_r[c] == '0) begin
							bwf_r[c] <= 1'b1; // R20
						end
						if (acc_n_r[c] != ctrl_r[C_ACC+1:C_ACC]) begin
							acc_n_r[c] <= acc_n_r[c] + 2'h1;
							acc_r[c] <= sum[c]; // R14
						end else begin
							acc_n_r[c] <= 2'h0;
							acc_r[c] <= '0;
							if (!inlim[c]) begin
								res_r[c][tgt_r[c]] <= sum[c]; // R15
								val_r[c][tgt_r[c]] <= 1'b1;
								limf_r[c] <= ctrl_r[C_LIM];
								if (ctrl_r[C_FIFO]) begin
									wp_r[c] <= wp_r[c] + 3'h1; // R15
								end
							end
						end
					end
				endcase
			end
		end
	end

	// register read port
	always_comb begin
		rdata_nxt = 16'h0000;
		unique case (i_bus.addr)
			A_CTRL: rdata_nxt = ctrl_r;
			A_TIME: rdata_nxt = time_r;
			A_PARA: rdata_nxt = par_mask_r[0];
			A_PARB: rdata_nxt = par_mask_r[1];
			A_TRIG: rdata_nxt = {8'h00, trig_en_r[1], trig_en_r[0]};
			A_LIMLO: rdata_nxt = lim_lo_r;
			A_LIMHI: rdata_nxt = lim_hi_r;
			A_WFR: rdata_nxt = {wfr_r[1], wfr_r[0]};
			A_DIGDIS: rdata_nxt = digdis_r;
			A_STAT: rdata_nxt = {8'h00, q_cnt_r[1] == 3'(QDEPTH), q_cnt_r[0] == 3'(QDEPTH),
				bwf_r, limf_r, ~idle};
			A_PINS: rdata_nxt = i_pin & ~digdis_r; // R8
			A_FIFOA: rdata_nxt = {val_r[0][rp_r[0]], 3'h0, res_r[0][rp_r[0]]};
			A_FIFOB: rdata_nxt = {val_r[1][rp_r[1]], 3'h0, res_r[1][rp_r[1]]};
			default: begin
				if (i_bus.addr[A_RES_BIT]) begin
					rdata_nxt = {val_r[i_bus.addr[3]][i_bus.addr[2:0]], 3'h0,
						res_r[i_bus.addr[3]][i_bus.addr[2:0]]};
				end
			end
		endcase
	end

	always_ff @(posedge i_clk_sys or negedge i_resetn) begin
		if (!i_resetn) begin
			o_rdata <= 16'h0000;
			o_mtest <= 1'b0;
		end else begin
			o_rdata <= i_bus.rd ? rdata_nxt : 16'h0000;
			o_mtest <= ctrl_r[C_MTEST]; // R20
		end
	end

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (!i_resetn);

	pwr_idle_off_a: assert property (idle[0] && !go[0] |=> !o_ana[0].pwr) // R19
		else $error("analog section on while idle");
	grant_power_a: assert property (go[0] |=> o_ana[0].pwr && o_ana[0].samp) // R19
		else $error("grant did not power and sample");
	sample_len_a: assert property (go[0] && time_r[7:0] == TIME_RST[7:0] // R5
		|=> o_ana[0].samp [*5] ##1 !o_ana[0].samp)
		else $error("sample phase length wrong");
	sync_start_a: assert property (go[0] && ctrl_r[C_SYNC] |=> o_ana[1].samp) // R6
		else $error("sync sampling not simultaneous");
	wfr_hold_a: assert property (st_r[0] == ST_STORE && wfr_r[0][tgt_r[0]] // R21
		|-> !val_r[0][tgt_r[0]])
		else $error("protected unread register targeted");
	insert_first_a: assert property (go[0] && ins_v_r[0] |-> gnt[0].src == SRC_INS) // R12
		else $error("insert not served first");
	par_order_a: assert property (go[0] && gnt[0].src == SRC_PAR // R10
		|-> (pend_r[0] & ((NCH'(1) << gnt[0].ch) - NCH'(1))) == '0)
		else $error("parallel order broken");
	queue_order_a: assert property (pop_q[0] |-> gnt[0].ch == q_r[0][0]) // R11
		else $error("queue order broken");
	done_pulse_a: assert property (st_r[0] == ST_STORE |=> o_done[0] ##1 !o_done[0]) // R17
		else $error("done not a single pulse");
	read_data_a: assert property (i_bus.rd |=> o_rdata == $past(rdata_nxt))
		else $error("read data not one cycle later");

	insert_run_c: cover property (go[0] && gnt[0].src == SRC_INS);
	sync_both_c: cover property (o_ana[0].samp && o_ana[1].samp && ctrl_r[C_SYNC]);
	fifo_done_c: cover property (o_done[0] && ctrl_r[C_FIFO]);
	wfr_block_c: cover property (blk[0] && gnt[0].v);
endmodule
`default_nettype wire

// [sim/arc_ana_model.sv]
// analog far side: per-channel input levels and one comparator per converter
// assumes registered analog control outputs from the converter control block
`default_nettype none
module arc_ana_model
	import arc_pkg::*;
(
	// clock
	input wire logic i_clk_sys,
	// converter side
	input wire arc_ana_t [NCONV-1:0] i_ana,
	input wire logic [NCH-1:0][SAR_W-1:0] i_level,
	output logic [NCONV-1:0] o_cmp
);
	timeunit 1ns;
	timeprecision 1ps;
	logic idle_r = 1'b0;
	// unpowered comparator gives no steady answer
	always @(posedge i_clk_sys) begin
		idle_r <= ~idle_r;
	end
	always_comb begin
		for (int c = 0; c < NCONV; c++) begin
			o_cmp[c] = i_ana[c].pwr ? (i_level[i_ana[c].sel] >= i_ana[c].dac) : idle_r;
		end
	end
endmodule
`default_nettype wire

// [sim/arc_top_bench.sv]
// self-checking bench: register tasks, conversion monitor, directed tests
// assumes arc_top and the analog comparator model
`default_nettype none
module arc_top_bench;
	import arc_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	logic i_clk_sys = 1'b0;
	logic i_resetn = 1'b0;
	arc_bus_t bus = '0;
	logic [15:0] rdata;
	logic [NCONV-1:0] etc = '0;
	logic [3:0] trig = '0;
	logic [NCONV-1:0] cmp;
	logic [NCH-1:0] pins = '0;
	arc_ana_t [NCONV-1:0] ana;
	logic mtest;
	logic [NCONV-1:0] done;
	logic [NCH-1:0][SAR_W-1:0] lvl;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	int nd[NCONV] = '{0, 0};
	int rise[NCONV] = '{0, 0};
	int lat = 0;
	logic [3:0] sels[$];
	logic [15:0] d;
	arc_top arc_top_inst (.i_clk_sys(i_clk_sys), .i_resetn(i_resetn), .i_bus(bus),
		.o_rdata(rdata), .i_trig(trig), .i_etc_start(etc), .i_cmp(cmp), .i_pin(pins),
		.o_ana(ana), .o_mtest(mtest), .o_done(done));
	arc_ana_model arc_ana_model_inst (.i_clk_sys(i_clk_sys), .i_ana(ana), .i_level(lvl),
		.o_cmp(cmp));
	initial begin
		forever #2 i_clk_sys = ~i_clk_sys;
	end
	always_comb begin
		for (int i = 0; i < NCH; i++) begin
			lvl[i] = 10'h3A5 - 10'(i * 65);
		end
	end
	// conversion monitor: start cycle, channel order, done count, latency
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
	end
	logic [NCONV-1:0] pwr_q = '0;
	always @(posedge i_clk_sys) begin
		for (int c = 0; c < NCONV; c++) begin
			pwr_q[c] <= ana[c].pwr;
			if (ana[c].pwr === 1'b1 && pwr_q[c] !== 1'b1) begin
				rise[c] <= cyc;
				if (c == 0) sels.push_back(ana[0].sel);
			end
			if (done[c] === 1'b1) begin
				nd[c] <= nd[c] + 1;
				if (c == 0) lat <= cyc - rise[0];
			end
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		compares++;
		if (got !== exp) begin
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
			n_mismatch++;
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [15:0] v);
		@(posedge i_clk_sys) bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(posedge i_clk_sys) bus <= '0;
	endtask
	task automatic rd(input logic [4:0] a, output logic [15:0] v);
		@(posedge i_clk_sys) bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
		@(posedge i_clk_sys) bus <= '0;
		#1 v = rdata;
	endtask
	task automatic rdchk(input logic [4:0] a, input logic [15:0] exp);
		logic [15:0] v;
		rd(a, v);
		chk(v, exp);
	endtask
	task automatic end_sim;
		$display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
		if (n_mismatch == 0 && compares > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask
	task automatic wait_done(input int c, input int n);
		int k;
		for (k = 0; k < 3000 && nd[c] < n; k++) @(posedge i_clk_sys);
		if (nd[c] < n) begin
			chk(16'(nd[c]), 16'(n));
			end_sim();
		end
		#1;
	endtask
	initial begin
		repeat (20) @(posedge i_clk_sys);
		i_resetn <= 1'b1;
		// reset values and write-only place
		rdchk(A_CTRL, CTRL_RST);
		rdchk(A_TIME, TIME_RST);
		rdchk(A_START, 16'h0000);
		rdchk(5'h1F, 16'h0000);
		rdchk(A_STAT, 16'h0000);
		chk({15'h0, ana[0].pwr}, 16'h0000);
		$display("test reset done");
		// parallel source, two channels, reset timing
		wr(A_CTRL, 16'h0001);
		wr(A_PARA, 16'h000A);
		wr(A_START, 16'h0001);
		wait_done(0, 2);
		chk({12'h0, sels[0]}, 16'h0001);
		chk({12'h0, sels[1]}, 16'h0003);
		chk(16'(lat), 16'h001A);
		chk({15'h0, ana[0].pwr}, 16'h0000);
		rdchk(5'h11, 16'h8000 | 16'(lvl[1]));
		rdchk(5'h13, 16'h8000 | 16'(lvl[3]));
		$display("test parallel done");
		// reduced resolution
		wr(A_CTRL, 16'h0005);
		wr(A_PARA, 16'h0004);
		wr(A_START, 16'h0001);
		wait_done(0, 3);
		chk(16'(lat), 16'h0016);
		rdchk(5'h12, 16'h8000 | 16'(lvl[2][9:2]));
		$display("test 8-bit done");
		// wait-for-read hold, restarted by the transfer controller
		wr(A_CTRL, 16'h0001);
		wr(A_WFR, 16'h0002);
		wr(A_PARA, 16'h0002);
		wr(A_START, 16'h0001);
		wait_done(0, 4);
		@(posedge i_clk_sys) etc <= 2'b01;
		@(posedge i_clk_sys) etc <= 2'b00;
		repeat (60) @(posedge i_clk_sys);
		chk(16'(nd[0]), 16'h0004);
		rdchk(5'h11, 16'h8000 | 16'(lvl[1]));
		wait_done(0, 5);
		rdchk(5'h11, 16'h8000 | 16'(lvl[1]));
		$display("test wait-for-read done");
		// queue order into the chained buffer
		wr(A_WFR, 16'h0000);
		wr(A_CTRL, 16'h0011);
		sels.delete();
		wr(A_QUEUE, 16'h0005);
		wr(A_QUEUE, 16'h0002);
		wr(A_QUEUE, 16'h0007);
		wait_done(0, 8);
		chk({12'h0, sels[0]}, 16'h0005);
		chk({12'h0, sels[1]}, 16'h0002);
		chk({12'h0, sels[2]}, 16'h0007);
		rdchk(A_FIFOA, 16'h8000 | 16'(lvl[5]));
		rdchk(A_FIFOA, 16'h8000 | 16'(lvl[2]));
		rdchk(A_FIFOA, 16'h8000 | 16'(lvl[7]));
		rd(A_FIFOA, d);
		chk({15'h0, d[15]}, 16'h0000);
		$display("test queue fifo done");
		// synchronised sampling on both converters
		wr(A_CTRL, 16'h000B);
		wr(A_PARA, 16'h0001);
		wr(A_PARB, 16'h0001);
		wr(A_START, 16'h0003);
		wait_done(0, 9);
		wait_done(1, 1);
		chk(16'(rise[0]), 16'(rise[1]));
		rdchk(5'h10, 16'h8000 | 16'(lvl[0]));
		rdchk(5'h18, 16'h8000 | 16'(lvl[0]));
		$display("test sync done");
		// digital pins, mux test, limit discard
		@(posedge i_clk_sys) pins <= 16'hA5C3;
		wr(A_DIGDIS, 16'h00F0);
		rdchk(A_PINS, 16'hA503);
		wr(A_CTRL, 16'h0200);
		repeat (2) @(posedge i_clk_sys);
		#1;
		chk({15'h0, mtest}, 16'h0001);
		wr(A_LIMLO, 16'h0000);
		wr(A_LIMHI, 16'h03FF);
		wr(A_CTRL, 16'h0021);
		wr(A_PARA, 16'h0010);
		wr(A_START, 16'h0001);
		wait_done(0, 10);
		rd(5'h14, d);
		chk({15'h0, d[15]}, 16'h0000);
		$display("test pins limit done");
		// trigger start with external multiplexer stepping
		wr(A_CTRL, 16'h0801);
		wr(A_PARA, 16'h0040);
		wr(A_TRIG, 16'h0001);
		@(posedge i_clk_sys) trig <= 4'h1;
		wait_done(0, 11);
		chk({13'h0, ana[0].emux}, 16'h0001);
		rdchk(5'h16, 16'h8000 | 16'(lvl[6]));
		$display("test trigger done");
		// insert first, then parallel above queue
		wr(A_CTRL, 16'h0000);
		wr(A_PARA, 16'h0008);
		wr(A_START, 16'h0001);
		wr(A_QUEUE, 16'h0005);
		wr(A_INSERT, 16'h0006);
		sels.delete();
		wr(A_CTRL, 16'h0401);
		wait_done(0, 14);
		chk({12'h0, sels[0]}, 16'h0006);
		chk({12'h0, sels[1]}, 16'h0003);
		chk({12'h0, sels[2]}, 16'h0005);
		rdchk(5'h16, 16'h8000 | 16'(lvl[6]));
		$display("test insert priority done");
		// two results accumulated into one
		wr(A_CTRL, 16'h0041);
		wr(A_PARA, 16'h0001);
		wr(A_START, 16'h0001);
		wr(A_START, 16'h0001);
		wait_done(0, 16);
		rdchk(5'h10, 16'h8000 | 16'(2 * lvl[0]));
		$display("test accumulate done");
		end_sim();
	end
endmodule
`default_nettype wire
